// ---- gism_top.sv ----
// Purpose: device-level interrupt summary and enable registers for eight ports
// Assumes: per-port interrupt flags come from logic on clk
// Notes:   registers reached over axi4-lite; ce low freezes all state
//
// Register access over AXI4-Lite was decided locally.
`default_nettype none

module gism_top
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        ce,
   input  wire logic [7:0]  framer_irq_flag,
   input  wire logic [7:0]  tester_irq_flag,
   input  wire logic [7:0]  line_unit_irq_flag,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             host_irq,
   output logic             event_irq
);

   typedef struct packed
   {
      logic [7:0] framer_sum;
      logic [7:0] tester_sum;
      logic [7:0] line_sum;
      logic [7:0] framer_en;
      logic [7:0] tester_en;
      logic [7:0] line_en;
      logic [2:0] evt_status;
      logic [2:0] evt_mask;
      logic [2:0] prev_hit;
      logic       host_irq;
      logic       evt_irq;
   } gism_regs_t;

   gism_regs_t st;
   gism_regs_t next_st;
   logic [2:0] group_hit;
   logic       wr_byte0;

   gism_reg_if rif();

   gism_axil_slave u_slave
   (
      .clk           (clk),
      .sys_rst       (sys_rst),
      .ce            (ce),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .rif           (rif.bus)
   );

   // enable gating per port
   gism_port_combine u_combine
   (
      .summary   ({st.line_sum, st.tester_sum, st.framer_sum}),
      .enable    ({st.line_en, st.tester_en, st.framer_en}),
      .group_hit (group_hit)
   );

   assign wr_byte0  = rif.wr_en & rif.wr_strb[0];
   assign host_irq  = st.host_irq;
   assign event_irq = st.evt_irq;

   // read mux
   always_comb
   begin
      rif.rd_data = gism_pkg::RD_ZERO;
      rif.rd_err  = 1'b0;
      case (rif.rd_idx)
         gism_pkg::IDX_FRAMER_SUM: rif.rd_data = {24'h0, st.framer_sum};
         gism_pkg::IDX_TESTER_SUM: rif.rd_data = {24'h0, st.tester_sum};
         gism_pkg::IDX_LINE_SUM:   rif.rd_data = {24'h0, st.line_sum};
         gism_pkg::IDX_FRAMER_EN:  rif.rd_data = {24'h0, st.framer_en};
         gism_pkg::IDX_TESTER_EN:  rif.rd_data = {24'h0, st.tester_en};
         gism_pkg::IDX_LINE_EN:    rif.rd_data = {24'h0, st.line_en};
         gism_pkg::IDX_EVT_STATUS: rif.rd_data = {29'h0, st.evt_status};
         gism_pkg::IDX_EVT_MASK:   rif.rd_data = {29'h0, st.evt_mask};
         default:                  rif.rd_err  = 1'b1;
      endcase
   end

   // write decode: all mapped indices accept, summaries ignoring the data; unmapped indices refuse
   always_comb
   begin
      case (rif.wr_idx)
         gism_pkg::IDX_FRAMER_SUM,
         gism_pkg::IDX_TESTER_SUM,
         gism_pkg::IDX_LINE_SUM,
         gism_pkg::IDX_FRAMER_EN,
         gism_pkg::IDX_TESTER_EN,
         gism_pkg::IDX_LINE_EN,
         gism_pkg::IDX_EVT_STATUS,
         gism_pkg::IDX_EVT_MASK:   rif.wr_err = 1'b0;
         default:                  rif.wr_err = 1'b1;
      endcase
   end

   always_comb
   begin
      next_st = st;
      // live summaries, one bit per port, bit 0 is port 1
      next_st.framer_sum = framer_irq_flag;
      next_st.tester_sum = tester_irq_flag;
      next_st.line_sum   = line_unit_irq_flag;
      if (wr_byte0)
      begin
         case (rif.wr_idx)
            gism_pkg::IDX_FRAMER_EN: next_st.framer_en = rif.wr_data[7:0];
            gism_pkg::IDX_TESTER_EN: next_st.tester_en = rif.wr_data[7:0];
            gism_pkg::IDX_LINE_EN:   next_st.line_en = rif.wr_data[7:0];
            gism_pkg::IDX_EVT_STATUS: next_st.evt_status = st.evt_status & ~rif.wr_data[2:0];
            gism_pkg::IDX_EVT_MASK:   next_st.evt_mask = rif.wr_data[2:0];
            default:                  next_st.evt_mask = st.evt_mask;
         endcase
      end
      // a new enabled group request sets its sticky bit, winning over a clear
      next_st.evt_status = next_st.evt_status | (group_hit & ~st.prev_hit);
      next_st.prev_hit   = group_hit;
      next_st.host_irq   = |group_hit;
      next_st.evt_irq    = |(next_st.evt_status & next_st.evt_mask);
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st            <= '0;
         st.framer_sum <= gism_pkg::RST_SUM;
         st.tester_sum <= gism_pkg::RST_SUM;
         st.line_sum   <= gism_pkg::RST_SUM;
         st.framer_en  <= gism_pkg::RST_EN;
         st.tester_en  <= gism_pkg::RST_EN;
         st.line_en    <= gism_pkg::RST_EN;
         st.evt_status <= gism_pkg::RST_EVT;
         st.evt_mask   <= gism_pkg::RST_EVT;
      end
      else if (ce)
      begin
         st <= next_st;
      end
   end

   a_line_sum_follows: assert property (@(posedge clk) disable iff (sys_rst)
      ce |=> st.line_sum == $past(line_unit_irq_flag))
      else $error("line unit summary does not follow its flags");

   a_tester_sum_follows: assert property (@(posedge clk) disable iff (sys_rst)
      ce |=> st.tester_sum == $past(tester_irq_flag))
      else $error("tester summary does not follow its flags");

   a_framer_en_write: assert property (@(posedge clk) disable iff (sys_rst)
      wr_byte0 && ce && rif.wr_idx == gism_pkg::IDX_FRAMER_EN
      |=> st.framer_en == $past(rif.wr_data[7:0]))
      else $error("framer enable write lost");

   a_tester_en_write: assert property (@(posedge clk) disable iff (sys_rst)
      wr_byte0 && ce && rif.wr_idx == gism_pkg::IDX_TESTER_EN
      |=> st.tester_en == $past(rif.wr_data[7:0]))
      else $error("tester enable write lost");

   a_line_en_write: assert property (@(posedge clk) disable iff (sys_rst)
      wr_byte0 && ce && rif.wr_idx == gism_pkg::IDX_LINE_EN
      |=> st.line_en == $past(rif.wr_data[7:0]))
      else $error("line unit enable write lost");

   a_enables_reset: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(sys_rst) |-> st.framer_en == 8'h00 && st.tester_en == 8'h00
                         && st.line_en == 8'h00)
      else $error("enables not clear after reset");

   a_framer_sum_rst: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(sys_rst) |-> st.framer_sum == 8'h00)
      else $error("framer summary not clear after reset");

   a_framer_sum_follows: assert property (@(posedge clk) disable iff (sys_rst)
      ce |=> st.framer_sum == $past(framer_irq_flag))
      else $error("framer summary does not follow its flags");

   a_other_sums_rst: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(sys_rst) |-> st.tester_sum == 8'h00 && st.line_sum == 8'h00)
      else $error("tester or line unit summary not clear after reset");

   a_tester_sum_addr: assert property (@(posedge clk) disable iff (sys_rst)
      rif.rd_idx == gism_pkg::IDX_TESTER_SUM |-> rif.rd_data == {24'h0, st.tester_sum}
                                                && !rif.rd_err)
      else $error("tester summary not readable at its address");

   a_host_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
      ce |=> host_irq == $past(|((st.framer_sum & st.framer_en) | (st.tester_sum & st.tester_en)
                                  | (st.line_sum & st.line_en))))
      else $error("host interrupt disagrees with summary and enable");

   a_event_sticky: assert property (@(posedge clk) disable iff (sys_rst)
      st.evt_status[0] && !(wr_byte0 && rif.wr_idx == gism_pkg::IDX_EVT_STATUS)
      |=> st.evt_status[0])
      else $error("sticky event bit lost without clear");

   a_event_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
      ce && group_hit[0] && !st.prev_hit[0] |=> st.evt_status[0])
      else $error("new framer group request did not set its event bit");

   a_state_frozen: assert property (@(posedge clk) disable iff (sys_rst)
      !ce |=> st == $past(st))
      else $error("state moved while clock enable low");

endmodule

`default_nettype wire

// ---- gism_pkg.sv ----
// Purpose: shared constants and types for the global interrupt summary and mask block
// Assumes: 100 MHz clk, 32-bit AXI4-Lite register access, eight ports
// Notes:   register indices are word indices, byte address is four times the index
`default_nettype none

package gism_pkg;

   localparam int          NPORT          = 8;
   localparam int          NGROUP         = 3;
   localparam int          IDX_W          = 10;
   localparam int          ADDR_W         = 12;

   // group positions inside the event status and mask registers
   localparam int          GRP_FRAMER     = 0;
   localparam int          GRP_TESTER     = 1;
   localparam int          GRP_LINE       = 2;

   // register indices
   localparam logic [9:0]  IDX_FRAMER_SUM = 10'h0f9;
   localparam logic [9:0]  IDX_TESTER_SUM = 10'h0fa;
   localparam logic [9:0]  IDX_LINE_SUM   = 10'h0fb;
   localparam logic [9:0]  IDX_FRAMER_EN  = 10'h0fc;
   localparam logic [9:0]  IDX_TESTER_EN  = 10'h0fd;
   localparam logic [9:0]  IDX_LINE_EN    = 10'h0fe;
   localparam logic [9:0]  IDX_EVT_STATUS = 10'h100;
   localparam logic [9:0]  IDX_EVT_MASK   = 10'h101;

   // byte addresses
   localparam logic [11:0] ADDR_FRAMER_SUM = {IDX_FRAMER_SUM, 2'h0};
   localparam logic [11:0] ADDR_TESTER_SUM = {IDX_TESTER_SUM, 2'h0};
   localparam logic [11:0] ADDR_LINE_SUM   = {IDX_LINE_SUM, 2'h0};
   localparam logic [11:0] ADDR_FRAMER_EN  = {IDX_FRAMER_EN, 2'h0};
   localparam logic [11:0] ADDR_TESTER_EN  = {IDX_TESTER_EN, 2'h0};
   localparam logic [11:0] ADDR_LINE_EN    = {IDX_LINE_EN, 2'h0};
   localparam logic [11:0] ADDR_EVT_STATUS = {IDX_EVT_STATUS, 2'h0};
   localparam logic [11:0] ADDR_EVT_MASK   = {IDX_EVT_MASK, 2'h0};

   // reset values
   localparam logic [7:0]  RST_SUM        = 8'h00;
   localparam logic [7:0]  RST_EN         = 8'h00;
   localparam logic [2:0]  RST_EVT        = 3'h0;

   // bus answers
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   localparam logic [31:0] RD_ZERO        = 32'h0000_0000;

   typedef enum logic [1:0]
   {
      GISM_WS_COLLECT = 2'b01,
      GISM_WS_RESP    = 2'b10
   } gism_wstate_t;

   typedef enum logic [1:0]
   {
      GISM_RS_IDLE = 2'b01,
      GISM_RS_DATA = 2'b10
   } gism_rstate_t;

endpackage

`default_nettype wire

// ---- gism_reg_if.sv ----
// Purpose: register access strobes between the bus slave and the register file
// Assumes: one clock, single-cycle write strobe, combinational read data
// Notes:   idx fields are word indices
`default_nettype none

interface gism_reg_if;
   logic        wr_en;
   logic [9:0]  wr_idx;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic        wr_err;
   logic [9:0]  rd_idx;
   logic [31:0] rd_data;
   logic        rd_err;

   modport bus
   (
      output wr_en,
      output wr_idx,
      output wr_data,
      output wr_strb,
      input  wr_err,
      output rd_idx,
      input  rd_data,
      input  rd_err
   );

   modport regs
   (
      input  wr_en,
      input  wr_idx,
      input  wr_data,
      input  wr_strb,
      output wr_err,
      input  rd_idx,
      output rd_data,
      output rd_err
   );
endinterface

`default_nettype wire

// ---- gism_axil_slave.sv ----
// Purpose: axi4-lite slave turning bus transfers into register strobes
// Assumes: one write and one read outstanding at most
// Notes:   write strobe in the first cycle that both address and data are held
`default_nettype none

module gism_axil_slave
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        ce,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   gism_reg_if.bus          rif
);

   typedef struct packed
   {
      gism_pkg::gism_wstate_t wst;
      gism_pkg::gism_rstate_t rst;
      logic                   aw_full;
      logic [9:0]             aw_idx;
      logic                   w_full;
      logic [31:0]            wdata;
      logic [3:0]             wstrb;
      logic [1:0]             bresp;
      logic [31:0]            rdata;
      logic [1:0]             rresp;
   } gism_slv_t;

   gism_slv_t st;
   gism_slv_t next_st;

   // valid outputs come straight from state, readies from state gated by ce
   assign s_axi_awready = ce & ~st.aw_full & (st.wst == gism_pkg::GISM_WS_COLLECT);
   assign s_axi_wready  = ce & ~st.w_full & (st.wst == gism_pkg::GISM_WS_COLLECT);
   assign s_axi_arready = ce & (st.rst == gism_pkg::GISM_RS_IDLE);
   assign s_axi_bvalid  = (st.wst == gism_pkg::GISM_WS_RESP);
   assign s_axi_rvalid  = (st.rst == gism_pkg::GISM_RS_DATA);
   assign s_axi_bresp   = st.bresp;
   assign s_axi_rdata   = st.rdata;
   assign s_axi_rresp   = st.rresp;

   assign rif.wr_en   = ce & st.aw_full & st.w_full & (st.wst == gism_pkg::GISM_WS_COLLECT);
   assign rif.wr_idx  = st.aw_idx;
   assign rif.wr_data = st.wdata;
   assign rif.wr_strb = st.wstrb;
   assign rif.rd_idx  = s_axi_araddr[11:2];

   always_comb
   begin
      next_st = st;
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_st.aw_full = 1'b1;
         next_st.aw_idx  = s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_st.w_full = 1'b1;
         next_st.wdata  = s_axi_wdata;
         next_st.wstrb  = s_axi_wstrb;
      end
      case (st.wst)
         gism_pkg::GISM_WS_COLLECT:
         begin
            if (rif.wr_en)
            begin
               next_st.aw_full = 1'b0;
               next_st.w_full  = 1'b0;
               next_st.bresp   = rif.wr_err ? gism_pkg::RESP_SLVERR : gism_pkg::RESP_OKAY;
               next_st.wst     = gism_pkg::GISM_WS_RESP;
            end
         end
         gism_pkg::GISM_WS_RESP:
         begin
            if (s_axi_bready)
            begin
               next_st.wst = gism_pkg::GISM_WS_COLLECT;
            end
         end
         default:
         begin
            next_st.wst = gism_pkg::GISM_WS_COLLECT;
         end
      endcase
      case (st.rst)
         gism_pkg::GISM_RS_IDLE:
         begin
            if (s_axi_arvalid && s_axi_arready)
            begin
               next_st.rdata = rif.rd_err ? gism_pkg::RD_ZERO : rif.rd_data;
               next_st.rresp = rif.rd_err ? gism_pkg::RESP_SLVERR : gism_pkg::RESP_OKAY;
               next_st.rst   = gism_pkg::GISM_RS_DATA;
            end
         end
         gism_pkg::GISM_RS_DATA:
         begin
            if (s_axi_rready)
            begin
               next_st.rst = gism_pkg::GISM_RS_IDLE;
            end
         end
         default:
         begin
            next_st.rst = gism_pkg::GISM_RS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st       <= '0;
         st.wst   <= gism_pkg::GISM_WS_COLLECT;
         st.rst   <= gism_pkg::GISM_RS_IDLE;
      end
      else if (ce)
      begin
         st <= next_st;
      end
   end

   a_bvalid_holds: assert property (@(posedge clk) disable iff (sys_rst)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before bready");

   a_rvalid_holds: assert property (@(posedge clk) disable iff (sys_rst)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed before rready");

endmodule

`default_nettype wire

// ---- gism_port_combine.sv ----
// Purpose: per-port gating of summary bits by their enables
// Assumes: three groups of eight ports
// Notes:   purely combinational
`default_nettype none

module gism_port_combine
(
   input  wire logic [2:0][7:0] summary,
   input  wire logic [2:0][7:0] enable,
   output logic [2:0]           group_hit
);

   logic [7:0][2:0] port_pass;

   // zero blocks, one passes
   genvar p;
   generate
      for (p = 0; p < gism_pkg::NPORT; p++)
      begin : g_port
         assign port_pass[p] = {summary[2][p] & enable[2][p],
                                summary[1][p] & enable[1][p],
                                summary[0][p] & enable[0][p]};
      end
   endgenerate

   always_comb
   begin
      group_hit = 3'h0;
      for (int i = 0; i < gism_pkg::NPORT; i++)
      begin
         group_hit = group_hit | port_pass[i];
      end
   end

endmodule

`default_nettype wire

// ---- gism_testbench.sv ----
// Purpose: self-checking bench for the global interrupt summary and mask block
// Assumes: 100 MHz clk, synchronous active-high reset, axi4-lite master in the bench
// Notes:   ordinary register cases run from a table; interrupt paths are hand-written
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed
   {
      logic [11:0] a;
      logic        wr;
      logic [31:0] d;
      logic [31:0] e;
      logic [1:0]  r;
   } gism_tb_row_t;

   logic        clk;
   logic        sys_rst;
   logic        ce;
   logic [7:0]  framer_irq_flag;
   logic [7:0]  tester_irq_flag;
   logic [7:0]  line_unit_irq_flag;
   logic [11:0] s_axi_awaddr;
   logic        s_axi_awvalid;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_wvalid;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready;
   logic [11:0] s_axi_araddr;
   logic        s_axi_arvalid;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready;
   logic        host_irq;
   logic        event_irq;
   int          miscompares;
   int          comparisons;
   logic [31:0] rd;
   logic [1:0]  rs;
   logic [11:0] en_addr [3];
   logic [11:0] sum_addr [3];
   gism_tb_row_t rows [18];

   gism_top u_gism_top
   (
      .clk                (clk),
      .sys_rst            (sys_rst),
      .ce                 (ce),
      .framer_irq_flag    (framer_irq_flag),
      .tester_irq_flag    (tester_irq_flag),
      .line_unit_irq_flag (line_unit_irq_flag),
      .s_axi_awaddr       (s_axi_awaddr),
      .s_axi_awvalid      (s_axi_awvalid),
      .s_axi_awready      (s_axi_awready),
      .s_axi_wdata        (s_axi_wdata),
      .s_axi_wstrb        (s_axi_wstrb),
      .s_axi_wvalid       (s_axi_wvalid),
      .s_axi_wready       (s_axi_wready),
      .s_axi_bresp        (s_axi_bresp),
      .s_axi_bvalid       (s_axi_bvalid),
      .s_axi_bready       (s_axi_bready),
      .s_axi_araddr       (s_axi_araddr),
      .s_axi_arvalid      (s_axi_arvalid),
      .s_axi_arready      (s_axi_arready),
      .s_axi_rdata        (s_axi_rdata),
      .s_axi_rresp        (s_axi_rresp),
      .s_axi_rvalid       (s_axi_rvalid),
      .s_axi_rready       (s_axi_rready),
      .host_irq           (host_irq),
      .event_irq          (event_irq)
   );

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
         miscompares++;
      end
   endtask

   task automatic results();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!(s_axi_bvalid && s_axi_bready));
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!(s_axi_rvalid && s_axi_rready));
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic do_reset();
      sys_rst <= 1'b1;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
   endtask

   task automatic set_flags(input logic [7:0] f, input logic [7:0] t, input logic [7:0] l);
      framer_irq_flag    <= f;
      tester_irq_flag    <= t;
      line_unit_irq_flag <= l;
      repeat (3) @(posedge clk);
   endtask

   initial
   begin
      #200us;
      miscompares++;
      results();
   end

   initial
   begin
      sys_rst = 1'b1;
      ce = 1'b1;
      framer_irq_flag = 8'h00;
      tester_irq_flag = 8'h00;
      line_unit_irq_flag = 8'h00;
      s_axi_awaddr = 12'h000;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hf;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 12'h000;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      miscompares = 0;
      comparisons = 0;
      en_addr = '{gism_pkg::ADDR_FRAMER_EN, gism_pkg::ADDR_TESTER_EN, gism_pkg::ADDR_LINE_EN};
      sum_addr = '{gism_pkg::ADDR_FRAMER_SUM, gism_pkg::ADDR_TESTER_SUM, gism_pkg::ADDR_LINE_SUM};
      rows = '{
         '{gism_pkg::ADDR_FRAMER_SUM, 1'b0, 32'h0, 32'h0, gism_pkg::RESP_OKAY},
         '{gism_pkg::ADDR_TESTER_SUM, 1'b0, 32'h0, 32'h0, gism_pkg::RESP_OKAY},
         '{gism_pkg::ADDR_LINE_SUM, 1'b0, 32'h0, 32'h0, gism_pkg::RESP_OKAY},
         '{gism_pkg::ADDR_FRAMER_EN, 1'b0, 32'h0, 32'h0, gism_pkg::RESP_OKAY},
         '{gism_pkg::ADDR_TESTER_EN, 1'b0, 32'h0, 32'h0, gism_pkg::RESP_OKAY},
         '{gism_pkg::ADDR_LINE_EN, 1'b0, 32'h0, 32'h0, gism_pkg::RESP_OKAY},
         '{gism_pkg::ADDR_FRAMER_EN, 1'b1, 32'h1234_56a5, 32'h0, gism_pkg::RESP_OKAY},
         '{gism_pkg::ADDR_FRAMER_EN, 1'b0, 32'h0, 32'h0000_00a5, gism_pkg::RESP_OKAY},
         '{gism_pkg::ADDR_TESTER_EN, 1'b1, 32'h0000_005a, 32'h0, gism_pkg::RESP_OKAY},
         '{gism_pkg::ADDR_TESTER_EN, 1'b0, 32'h0, 32'h0000_005a, gism_pkg::RESP_OKAY},
         '{gism_pkg::ADDR_LINE_EN, 1'b1, 32'hffff_ffc3, 32'h0, gism_pkg::RESP_OKAY},
         '{gism_pkg::ADDR_LINE_EN, 1'b0, 32'h0, 32'h0000_00c3, gism_pkg::RESP_OKAY},
         '{gism_pkg::ADDR_LINE_SUM, 1'b1, 32'h0000_00ff, 32'h0, gism_pkg::RESP_OKAY},
         '{gism_pkg::ADDR_LINE_SUM, 1'b0, 32'h0, 32'h0, gism_pkg::RESP_OKAY},
         '{12'h3fc, 1'b1, 32'h0000_00ff, 32'h0, gism_pkg::RESP_SLVERR},
         '{12'h3fc, 1'b0, 32'h0, gism_pkg::RD_ZERO, gism_pkg::RESP_SLVERR},
         '{gism_pkg::ADDR_EVT_MASK, 1'b1, 32'hffff_ffff, 32'h0, gism_pkg::RESP_OKAY},
         '{gism_pkg::ADDR_EVT_MASK, 1'b0, 32'h0, 32'h0000_0007, gism_pkg::RESP_OKAY}
      };
      do_reset();
      // register table: reset values, byte-0 writes, read-only and unmapped places
      foreach (rows[i])
      begin
         if (rows[i].wr)
            axi_write(rows[i].a, rows[i].d, rs);
         else
         begin
            axi_read(rows[i].a, rd, rs);
            chk(rd, rows[i].e);
         end
         chk({30'h0, rs}, {30'h0, rows[i].r});
      end
      for (int g = 0; g < 3; g++)
         axi_write(en_addr[g], 32'h0, rs);
      // walking port bits through all three summaries, enables closed
      for (int p = 0; p < 8; p++)
      begin
         set_flags(8'h01 << p, 8'h80 >> p, ~(8'h01 << p));
         axi_read(gism_pkg::ADDR_FRAMER_SUM, rd, rs);
         chk(rd, {24'h0, 8'h01 << p});
         axi_read(gism_pkg::ADDR_TESTER_SUM, rd, rs);
         chk(rd, {24'h0, 8'h80 >> p});
         axi_read(gism_pkg::ADDR_LINE_SUM, rd, rs);
         chk(rd, {24'h0, ~(8'h01 << p)});
         chk({31'h0, host_irq}, 32'h0);
      end
      set_flags(8'h00, 8'h00, 8'h00);
      // per-group gating, combined output and sticky event with clear
      for (int g = 0; g < 3; g++)
      begin
         axi_write(en_addr[g], 32'h0000_0010, rs);
         set_flags(g == 0 ? 8'hef : 8'h00, g == 1 ? 8'hef : 8'h00, g == 2 ? 8'hef : 8'h00);
         chk({31'h0, host_irq}, 32'h0);
         set_flags(g == 0 ? 8'h10 : 8'h00, g == 1 ? 8'h10 : 8'h00, g == 2 ? 8'h10 : 8'h00);
         chk({31'h0, host_irq}, 32'h1);
         chk({31'h0, event_irq}, 32'h1);
         set_flags(8'h00, 8'h00, 8'h00);
         chk({31'h0, host_irq}, 32'h0);
         axi_read(gism_pkg::ADDR_EVT_STATUS, rd, rs);
         chk(rd, 32'h1 << g);
         axi_write(gism_pkg::ADDR_EVT_STATUS, 32'h1 << g, rs);
         axi_read(gism_pkg::ADDR_EVT_STATUS, rd, rs);
         chk(rd, 32'h0);
         chk({31'h0, event_irq}, 32'h0);
         axi_write(en_addr[g], 32'h0, rs);
      end
      // only byte lane 0 carries the enable bits
      s_axi_wstrb <= 4'he;
      axi_write(gism_pkg::ADDR_FRAMER_EN, 32'h0000_00ff, rs);
      s_axi_wstrb <= 4'hf;
      axi_read(gism_pkg::ADDR_FRAMER_EN, rd, rs);
      chk(rd, 32'h0);
      // late rready: read data stands until taken
      s_axi_araddr  <= gism_pkg::ADDR_EVT_MASK;
      s_axi_arvalid <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      repeat (3) @(posedge clk);
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (!s_axi_rvalid);
      rd = s_axi_rdata;
      s_axi_rready <= 1'b0;
      chk(rd, 32'h0000_0007);
      // clock enable low refuses bus requests
      ce <= 1'b0;
      @(posedge clk);
      chk({29'h0, s_axi_awready, s_axi_wready, s_axi_arready}, 32'h0);
      ce <= 1'b1;
      @(posedge clk);
      // enables cleared by a reset in mid-run
      for (int g = 0; g < 3; g++)
         axi_write(en_addr[g], 32'h0000_00ff, rs);
      do_reset();
      for (int g = 0; g < 3; g++)
      begin
         axi_read(en_addr[g], rd, rs);
         chk(rd, 32'h0);
      end
      results();
   end
endmodule

`default_nettype wire
